// [sef_pkg.sv]
package sef_pkg;
  // Bus and stored-word geometry
  localparam int unsigned SEF_AW      = 32;
  localparam int unsigned SEF_DW      = 32;
  localparam int unsigned SEF_VER_W   = 16;
  localparam int unsigned SEF_TAG_W   = 16;
  localparam int unsigned SEF_NVM_W   = 64;
  localparam int unsigned SEF_CT_LSB  = 0;
  localparam int unsigned SEF_TAG_LSB = 32;
  localparam int unsigned SEF_VER_LSB = 48;
  // Values after reset: partition empty, windows closed, versions zero
  localparam logic [31:0] SEF_PART_BASE_RST = 32'hffff_ffff;
  localparam logic [31:0] SEF_PART_LIM_RST  = 32'h0000_0000;
  localparam logic [31:0] SEF_WIN_RST       = 32'h0000_0000;
  localparam logic [15:0] SEF_VER_RST       = 16'h0000;
  localparam logic [15:0] SEF_VER_STEP      = 16'h0001;
  // Synchroniser depth for the test-mode pin
  localparam int unsigned SEF_SYNC_CYC = 2;

  typedef enum logic [1:0] {SEF_FW_IDLE, SEF_FW_FWD} sef_fw_st_t;
  typedef enum logic [1:0] {SEF_NV_IDLE, SEF_NV_WAIT} sef_nv_st_t;
  typedef enum logic [1:0] {SEF_OP_WRITE, SEF_OP_DELETE, SEF_OP_READ} sef_op_t;
endpackage

// [sef_firewall.sv]
// Notes on behaviour
// - The firewall windows and the partition bounds are written only from the enclave-side config port.
// - An outside request reaches the enclave bus only through a matching open window, otherwise it is refused.
// - No outside component can read or change an enclave asset except through a window the enclave opened.
// - Each window gates its own functional domain in hardware, with a separate write permission.
// - A store write or delete is acknowledged only after the memory reports a successful update.
// - While test mode is set the protection key is forced to zero and every store request is refused.
// - The protection key enters from inside the enclave and never appears on any output.
// - Outside requests that fall inside the private partition of shared memory are blocked.
// - Shared-memory access is arbitrated by a plain request and done handshake, whatever the memory is.
// - Enclave data goes to shared memory only as ciphertext, and a read back is decrypted inside.
// - Each slot carries a version held inside; a read of an older stored version is rejected.
// - Pad and tag mix in the instance identity, so another instance cannot use the stored image.
// - Each image is masked with a pad tied to its own version, so an old pad does not open a new image.
// - Every stored word carries an integrity tag checked on read back; versions reset to zero, so words stored before a power cycle fail the version check.
`timescale 1ns/1ps
`default_nettype none
module sef_firewall
  import sef_pkg::*;
#(
  parameter int unsigned NWIN    = 2,
  parameter int unsigned NSLOT   = 16,
  parameter logic [31:0] INST_ID = 32'h3c5a_0001  // Arbitrary value
)(
  input  wire logic                 i_core_clk,
  input  wire logic                 i_nrst,
  input  wire logic                 i_test_mode,
  input  wire logic [31:0]          i_key,
  input  wire logic                 i_win_we,
  input  wire logic [$clog2(NWIN)-1:0] i_win_idx,
  input  wire logic [31:0]          i_win_base,
  input  wire logic [31:0]          i_win_lim,
  input  wire logic                 i_win_en,
  input  wire logic                 i_win_wr,
  input  wire logic                 i_part_we,
  input  wire logic [31:0]          i_part_base,
  input  wire logic [31:0]          i_part_lim,
  input  wire logic                 i_ext_valid,
  input  wire logic                 i_ext_write,
  input  wire logic [31:0]          i_ext_addr,
  input  wire logic [31:0]          i_ext_wdata,
  output logic                      o_ext_ready,
  output logic                      o_ext_rvalid,
  output logic                      o_ext_err,
  output logic [31:0]               o_ext_rdata,
  output logic                      o_enc_valid,
  output logic                      o_enc_write,
  output logic [31:0]               o_enc_addr,
  output logic [31:0]               o_enc_wdata,
  input  wire logic                 i_enc_resp_valid,
  input  wire logic [31:0]          i_enc_rdata,
  input  wire logic                 i_st_valid,
  input  wire sef_op_t              i_st_op,
  input  wire logic [31:0]          i_st_addr,
  input  wire logic [31:0]          i_st_data,
  output logic                      o_st_ready,
  output logic                      o_st_ack,
  output logic                      o_st_err,
  output logic [31:0]               o_st_rdata,
  output logic                      o_nvm_valid,
  output logic                      o_nvm_write,
  output logic [31:0]               o_nvm_addr,
  output logic [SEF_NVM_W-1:0]      o_nvm_wdata,
  input  wire logic                 i_nvm_done,
  input  wire logic                 i_nvm_ok,
  input  wire logic [SEF_NVM_W-1:0] i_nvm_rdata,
  input  wire logic                 i_soc_nvm_valid,
  input  wire logic [31:0]          i_soc_nvm_addr,
  output logic                      o_soc_nvm_grant,
  output logic                      o_soc_nvm_block
);

  localparam int unsigned SW = $clog2(NSLOT);

  typedef struct packed {
    sef_fw_st_t                  fst;
    logic                        ext_rvalid;
    logic                        ext_err;
    logic [31:0]                 ext_rdata;
    logic                        enc_valid;
    logic                        enc_write;
    logic [31:0]                 enc_addr;
    logic [31:0]                 enc_wdata;
    logic [NWIN-1:0][31:0]       wbase;
    logic [NWIN-1:0][31:0]       wlim;
    logic [NWIN-1:0]             wen;
    logic [NWIN-1:0]             wwr;
    logic [31:0]                 pbase;
    logic [31:0]                 plim;
    sef_nv_st_t                  nst;
    sef_op_t                     op;
    logic [31:0]                 saddr;
    logic [SEF_VER_W-1:0]        sver;
    logic                        st_ack;
    logic                        st_err;
    logic [31:0]                 st_rdata;
    logic                        nvm_valid;
    logic                        nvm_write;
    logic [31:0]                 nvm_addr;
    logic [SEF_NVM_W-1:0]        nvm_wdata;
    logic [NSLOT-1:0][SEF_VER_W-1:0] ver;
    logic                        tm1;
    logic                        tm2;
  } sef_state_t;

  sef_state_t st_r;
  sef_state_t st_nxt;

  // Toy mixing; a real cipher core replaces these two, ports stay the same
  function automatic logic [31:0] f_pad(input logic [31:0] k, input logic [31:0] a, input logic [15:0] v);
    f_pad = {k[15:0], k[31:16]} ^ a ^ {v, ~v} ^ INST_ID;
  endfunction

  function automatic logic [15:0] f_tag(input logic [31:0] ct, input logic [31:0] a, input logic [15:0] v,
                                        input logic [31:0] k);
    f_tag = ct[31:16] ^ ct[15:0] ^ a[15:0] ^ v ^ k[31:16] ^ INST_ID[31:16];
  endfunction

  logic [NWIN-1:0]   win_match;
  logic              win_hit;
  logic [31:0]       key_eff;
  logic [31:0]       st_phys;
  logic [SW-1:0]     slot;
  logic [SEF_VER_W-1:0] new_ver;
  logic [31:0]       new_ct;
  logic [SEF_VER_W-1:0] rd_ver;
  logic [SEF_TAG_W-1:0] rd_tag;
  logic [31:0]       rd_ct;
  logic              rd_good;

  // One comparator pair per window; write needs its own permission bit
  for (genvar g = 0; g < NWIN; g++) begin : g_win
    assign win_match[g] = st_r.wen[g] && i_ext_addr >= st_r.wbase[g] && i_ext_addr <= st_r.wlim[g] &&
                          (!i_ext_write || st_r.wwr[g]);
  end
  assign win_hit = |win_match;

  // Key is dropped in test mode and used only in local arithmetic
  assign key_eff = st_r.tm2 ? 32'h0000_0000 : i_key;
  assign st_phys = st_r.pbase + i_st_addr;
  assign slot    = st_r.saddr[SW-1:0];
  assign new_ver = st_r.ver[i_st_addr[SW-1:0]] + SEF_VER_STEP;
  assign new_ct  = (i_st_op == SEF_OP_DELETE) ? 32'h0000_0000 : i_st_data ^ f_pad(key_eff, i_st_addr, new_ver);
  assign rd_ver  = i_nvm_rdata[SEF_VER_LSB +: SEF_VER_W];
  assign rd_tag  = i_nvm_rdata[SEF_TAG_LSB +: SEF_TAG_W];
  assign rd_ct   = i_nvm_rdata[SEF_CT_LSB +: 32];
  // Stale version or bad tag both reject the word
  assign rd_good = rd_ver == st_r.ver[slot] && rd_tag == f_tag(rd_ct, st_r.saddr, rd_ver, key_eff);

  always_comb begin
    st_nxt            = st_r;
    st_nxt.ext_rvalid = 1'b0;
    st_nxt.st_ack     = 1'b0;
    st_nxt.st_err     = 1'b0;
    // Pin synchroniser, first stage read only by the second
    st_nxt.tm1        = i_test_mode;
    st_nxt.tm2        = st_r.tm1;

    // Configuration reachable from the enclave side only
    if (i_win_we) begin
      st_nxt.wbase[i_win_idx] = i_win_base;
      st_nxt.wlim[i_win_idx]  = i_win_lim;
      st_nxt.wen[i_win_idx]   = i_win_en;
      st_nxt.wwr[i_win_idx]   = i_win_wr;
    end
    if (i_part_we) begin
      st_nxt.pbase = i_part_base;
      st_nxt.plim  = i_part_lim;
    end

    // Outside initiator path
    unique case (st_r.fst)
      SEF_FW_IDLE: begin
        if (i_ext_valid) begin
          if (win_hit) begin
            st_nxt.enc_valid = 1'b1;
            st_nxt.enc_write = i_ext_write;
            st_nxt.enc_addr  = i_ext_addr;
            st_nxt.enc_wdata = i_ext_wdata;
            st_nxt.fst       = SEF_FW_FWD;
          end else begin
            st_nxt.ext_rvalid = 1'b1;
            st_nxt.ext_err    = 1'b1;
            st_nxt.ext_rdata  = 32'h0000_0000;
          end
        end
      end
      SEF_FW_FWD: begin
        if (i_enc_resp_valid) begin
          st_nxt.enc_valid  = 1'b0;
          st_nxt.ext_rvalid = 1'b1;
          st_nxt.ext_err    = 1'b0;
          st_nxt.ext_rdata  = st_r.enc_write ? 32'h0000_0000 : i_enc_rdata;
          st_nxt.fst        = SEF_FW_IDLE;
        end
      end
    endcase

    // Protected store path; request held until done
    unique case (st_r.nst)
      SEF_NV_IDLE: begin
        if (i_st_valid) begin
          if (st_r.tm2 || st_phys > st_r.plim || st_phys < st_r.pbase) begin
            st_nxt.st_err = 1'b1;
          end else begin
            st_nxt.op        = i_st_op;
            st_nxt.saddr     = i_st_addr;
            st_nxt.sver      = new_ver;
            st_nxt.nvm_valid = 1'b1;
            st_nxt.nvm_write = i_st_op != SEF_OP_READ;
            st_nxt.nvm_addr  = st_phys;
            st_nxt.nvm_wdata = {new_ver, f_tag(new_ct, i_st_addr, new_ver, key_eff), new_ct};
            st_nxt.nst       = SEF_NV_WAIT;
          end
        end
      end
      SEF_NV_WAIT: begin
        if (i_nvm_done) begin
          st_nxt.nvm_valid = 1'b0;
          st_nxt.nst       = SEF_NV_IDLE;
          if (st_r.op != SEF_OP_READ) begin
            // Version advances only once the update is committed
            if (i_nvm_ok) begin
              st_nxt.ver[slot] = st_r.sver;
              st_nxt.st_ack    = 1'b1;
            end else begin
              st_nxt.st_err = 1'b1;
            end
          end else if (i_nvm_ok && rd_good) begin
            st_nxt.st_ack   = 1'b1;
            st_nxt.st_rdata = rd_ct ^ f_pad(key_eff, st_r.saddr, rd_ver);
          end else begin
            st_nxt.st_err   = 1'b1;
            st_nxt.st_rdata = 32'h0000_0000;
          end
        end
      end
    endcase
  end

  // Single state register
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r       <= '0;
      st_r.fst   <= SEF_FW_IDLE;
      st_r.nst   <= SEF_NV_IDLE;
      st_r.op    <= SEF_OP_WRITE;
      st_r.wbase <= {NWIN{SEF_WIN_RST}};
      st_r.wlim  <= {NWIN{SEF_WIN_RST}};
      st_r.pbase <= SEF_PART_BASE_RST;
      st_r.plim  <= SEF_PART_LIM_RST;
      st_r.ver   <= {NSLOT{SEF_VER_RST}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Ready is combinational so a request is taken in the same edge
  assign o_ext_ready  = st_r.fst == SEF_FW_IDLE;
  assign o_ext_rvalid = st_r.ext_rvalid;
  assign o_ext_err    = st_r.ext_err;
  assign o_ext_rdata  = st_r.ext_rdata;
  assign o_enc_valid  = st_r.enc_valid;
  assign o_enc_write  = st_r.enc_write;
  assign o_enc_addr   = st_r.enc_addr;
  assign o_enc_wdata  = st_r.enc_wdata;
  assign o_st_ready   = st_r.nst == SEF_NV_IDLE;
  assign o_st_ack     = st_r.st_ack;
  assign o_st_err     = st_r.st_err;
  assign o_st_rdata   = st_r.st_rdata;
  assign o_nvm_valid  = st_r.nvm_valid;
  assign o_nvm_write  = st_r.nvm_write;
  assign o_nvm_addr   = st_r.nvm_addr;
  assign o_nvm_wdata  = st_r.nvm_wdata;

  // Outside memory requests into the partition are cut off
  assign o_soc_nvm_block = i_soc_nvm_valid && i_soc_nvm_addr >= st_r.pbase && i_soc_nvm_addr <= st_r.plim;
  assign o_soc_nvm_grant = i_soc_nvm_valid && !o_soc_nvm_block;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_fwd_done;
    o_enc_valid && i_enc_resp_valid ##1 o_ext_rvalid;
  endsequence
  sequence s_tm_held;
    i_test_mode [*3];
  endsequence

  property p_miss_err;
    o_ext_ready && i_ext_valid && !win_hit |=> o_ext_rvalid && o_ext_err && o_ext_rdata == 32'h0000_0000;
  endproperty
  a_miss_err: assert property (p_miss_err) else $error("refused access not answered with error");

  property p_fwd_only_hit;
    $rose(o_enc_valid) |-> $past(win_hit) && $past(i_ext_valid);
  endproperty
  a_fwd_only_hit: assert property (p_fwd_only_hit) else $error("enclave bus driven without open window");

  property p_fwd_resp;
    s_fwd_done |-> !o_ext_err && !o_enc_valid;
  endproperty
  a_fwd_resp: assert property (p_fwd_resp) else $error("forwarded access answered wrongly");

  property p_ack_commit;
    o_st_ack |-> $past(i_nvm_done) && $past(i_nvm_ok);
  endproperty
  a_ack_commit: assert property (p_ack_commit) else $error("store acknowledged before commit");

  property p_test_refuse;
    s_tm_held ##0 (o_st_ready && i_st_valid) |=> o_st_err && !o_nvm_valid;
  endproperty
  a_test_refuse: assert property (p_test_refuse) else $error("store accepted in test mode");

  property p_soc_block;
    i_part_we ##1 i_soc_nvm_valid && i_soc_nvm_addr >= $past(i_part_base) && i_soc_nvm_addr <= $past(i_part_lim)
      |-> o_soc_nvm_block && !o_soc_nvm_grant;
  endproperty
  a_soc_block: assert property (p_soc_block) else $error("outside access granted into partition");

  property p_stale_reject;
    o_nvm_valid && !o_nvm_write && i_nvm_done && rd_ver != st_r.ver[slot] |=> o_st_err && !o_st_ack;
  endproperty
  a_stale_reject: assert property (p_stale_reject) else $error("older stored image accepted");

  property p_nvm_hold;
    o_nvm_valid && !i_nvm_done |=> o_nvm_valid && $stable(o_nvm_addr) && $stable(o_nvm_wdata);
  endproperty
  a_nvm_hold: assert property (p_nvm_hold) else $error("memory request dropped before done");

  property p_cfg_idle;
    !i_win_we |=> $stable(st_r.wen) && $stable(st_r.wwr);
  endproperty
  a_cfg_idle: assert property (p_cfg_idle) else $error("window changed without enclave write");

endmodule
`default_nettype wire

// [sef_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sef_far_model
  import sef_pkg::*;
(
  input  wire logic                 i_core_clk,
  input  wire logic                 i_slow,
  input  wire logic                 i_nvm_fail,
  input  wire logic [1:0]           i_rd_mode,
  input  wire logic                 i_enc_valid,
  input  wire logic [31:0]          i_enc_addr,
  output logic                      o_enc_resp_valid,
  output logic [31:0]               o_enc_rdata,
  input  wire logic                 i_nvm_valid,
  input  wire logic                 i_nvm_write,
  input  wire logic [31:0]          i_nvm_addr,
  input  wire logic [SEF_NVM_W-1:0] i_nvm_wdata,
  output logic                      o_nvm_done,
  output logic                      o_nvm_ok,
  output logic [SEF_NVM_W-1:0]      o_nvm_rdata
);
  logic [SEF_NVM_W-1:0] mem [logic [31:0]];
  logic [SEF_NVM_W-1:0] old [logic [31:0]];
  int                   ecnt = 0;
  int                   ncnt = 0;
  initial begin
    {o_enc_resp_valid, o_enc_rdata, o_nvm_done, o_nvm_ok, o_nvm_rdata} = '0;
  end
  // Enclave bus sees only what the firewall let through; answer is the inverted address
  always @(negedge i_core_clk) begin
    o_enc_resp_valid <= 1'b0;
    if (i_enc_valid && !o_enc_resp_valid && ecnt >= (i_slow ? 3 : 0)) begin
      o_enc_resp_valid <= 1'b1;
      o_enc_rdata      <= ~i_enc_addr;
      ecnt             <= 0;
    end else begin
      o_enc_rdata <= ~o_enc_rdata;  // Released bus keeps moving
      ecnt        <= i_enc_valid ? ecnt + 1 : 0;
    end
  end
  // Shared store at absolute addresses chosen by the enclave; keeps one old image for rollback
  always @(negedge i_core_clk) begin
    o_nvm_done <= 1'b0;
    if (i_nvm_valid && !o_nvm_done && ncnt >= (i_slow ? 3 : 0)) begin
      o_nvm_done <= 1'b1;
      o_nvm_ok   <= !i_nvm_fail;
      ncnt       <= 0;
      if (i_nvm_write && !i_nvm_fail) begin
        if (mem.exists(i_nvm_addr)) old[i_nvm_addr] = mem[i_nvm_addr];
        mem[i_nvm_addr] = i_nvm_wdata;
      end
      if (i_rd_mode == 2'h1 && old.exists(i_nvm_addr)) o_nvm_rdata <= old[i_nvm_addr];
      else if (mem.exists(i_nvm_addr)) o_nvm_rdata <= mem[i_nvm_addr] ^ (i_rd_mode == 2'h2 ? 64'h1_0000_0000 : '0);
      else o_nvm_rdata <= ~o_nvm_rdata;
    end else begin
      o_nvm_rdata <= ~o_nvm_rdata;  // Not answering: no stale word left on the lines
      ncnt        <= i_nvm_valid ? ncnt + 1 : 0;
    end
  end
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb
  import sef_pkg::*;
;
  logic        clk, nrst, tmode, win_we, win_en, win_wr, part_we, ext_v, ext_w, ext_rdy, ext_rv, ext_err, slow, fail;
  logic        enc_v, enc_w, enc_rv, st_v, st_rdy, st_ack, st_err, nv_v, nv_w, nv_done, nv_ok, soc_v, soc_g, soc_b;
  logic [0:0]  win_idx;
  logic [1:0]  rd_mode;
  logic [15:0] rnd;
  logic [31:0] key, wbase, wlim, pbase, plim, ext_a, ext_d, ext_rd, enc_a, enc_d, enc_rd, st_a, st_d, st_rd;
  logic [31:0] nv_a, soc_a, last_a, d1, d2;
  logic [63:0] nv_wd, nv_rd, last_wd;
  sef_op_t     st_op;
  logic        nv_q = 1'b0;
  int          n_fail = 0, total_checks = 0, n_nvm = 0, cyc = 0;
  logic [31:0] corner [6] = '{32'h0000_0fff, 32'h0000_1000, 32'h0000_1fff, 32'h0000_2000, 32'h0000_80ff, 32'h0000_8100};

  sef_firewall dut_u (.i_core_clk(clk), .i_nrst(nrst), .i_test_mode(tmode), .i_key(key), .i_win_we(win_we),
    .i_win_idx(win_idx), .i_win_base(wbase), .i_win_lim(wlim), .i_win_en(win_en), .i_win_wr(win_wr),
    .i_part_we(part_we), .i_part_base(pbase), .i_part_lim(plim), .i_ext_valid(ext_v), .i_ext_write(ext_w),
    .i_ext_addr(ext_a), .i_ext_wdata(ext_d), .o_ext_ready(ext_rdy), .o_ext_rvalid(ext_rv), .o_ext_err(ext_err),
    .o_ext_rdata(ext_rd), .o_enc_valid(enc_v), .o_enc_write(enc_w), .o_enc_addr(enc_a), .o_enc_wdata(enc_d),
    .i_enc_resp_valid(enc_rv), .i_enc_rdata(enc_rd), .i_st_valid(st_v), .i_st_op(st_op), .i_st_addr(st_a),
    .i_st_data(st_d), .o_st_ready(st_rdy), .o_st_ack(st_ack), .o_st_err(st_err), .o_st_rdata(st_rd),
    .o_nvm_valid(nv_v), .o_nvm_write(nv_w), .o_nvm_addr(nv_a), .o_nvm_wdata(nv_wd), .i_nvm_done(nv_done),
    .i_nvm_ok(nv_ok), .i_nvm_rdata(nv_rd), .i_soc_nvm_valid(soc_v), .i_soc_nvm_addr(soc_a),
    .o_soc_nvm_grant(soc_g), .o_soc_nvm_block(soc_b));
  sef_far_model far_u (.i_core_clk(clk), .i_slow(slow), .i_nvm_fail(fail), .i_rd_mode(rd_mode), .i_enc_valid(enc_v),
    .i_enc_addr(enc_a), .o_enc_resp_valid(enc_rv), .o_enc_rdata(enc_rd), .i_nvm_valid(nv_v), .i_nvm_write(nv_w),
    .i_nvm_addr(nv_a), .i_nvm_wdata(nv_wd), .o_nvm_done(nv_done), .o_nvm_ok(nv_ok), .o_nvm_rdata(nv_rd));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Window 0 is read-only and may be switched off, window 1 allows both directions
  function automatic logic fw_hit(input logic [31:0] a, input logic w, input logic w0_on);
    return (w0_on && !w && a >= 32'h0000_1000 && a <= 32'h0000_1fff) || (a >= 32'h0000_8000 && a <= 32'h0000_80ff);
  endfunction
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Cycle ceiling: 5000 cycles, far above about 90 task calls of at most a dozen cycles each
  always @(posedge clk) begin
    nv_q <= nv_v;
    cyc  <= cyc + 1;
    if (nv_v && !nv_q) begin
      n_nvm   <= n_nvm + 1;
      last_a  <= nv_a;
      last_wd <= nv_wd;
    end
    if (cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end
  // All tasks start and end on a falling edge
  task automatic cfg_win(input logic idx, input logic en, input logic wr, input logic [31:0] b, input logic [31:0] l);
    win_we = 1'b1; win_idx = idx; win_en = en; win_wr = wr; wbase = b; wlim = l;
    @(negedge clk);
    win_we = 1'b0;
    @(negedge clk);
  endtask
  task automatic cfg_part(input logic [31:0] b, input logic [31:0] l);
    part_we = 1'b1; pbase = b; plim = l;
    @(negedge clk);
    part_we = 1'b0;
    @(negedge clk);
  endtask
  task automatic ext(input logic [31:0] a, input logic w, input logic w0_on);
    logic hit, seen;
    int   t;
    hit = fw_hit(a, w, w0_on); seen = 1'b0; t = 0;
    ext_v = 1'b1; ext_w = w; ext_a = a; ext_d = ~a;
    @(negedge clk);
    ext_v = 1'b0;
    while (ext_rv !== 1'b1 && t < 30) begin
      if (enc_v === 1'b1 && !seen) begin
        seen = 1'b1;
        chk({enc_w, enc_a, w ? enc_d : ~a}, {w, a, ~a});
      end
      @(negedge clk);
      t++;
    end
    chk({ext_rv, ext_err, ext_rd}, {1'b1, !hit, (hit && !w) ? ~a : 32'h0000_0000});
    chk(seen, hit);
    @(negedge clk);
  endtask
  task automatic st(input sef_op_t op, input logic [31:0] off, input logic [31:0] d, input logic ok, input int nreq);
    int t, n0;
    t = 0; n0 = n_nvm;
    st_v = 1'b1; st_op = op; st_a = off; st_d = d;
    @(negedge clk);
    st_v = 1'b0;
    while (st_ack !== 1'b1 && st_err !== 1'b1 && t < 30) begin
      @(negedge clk);
      t++;
    end
    chk({st_ack, st_err, n_nvm - n0}, {ok, !ok, nreq});
    if (op == SEF_OP_READ && ok) chk(st_rd, d);
    if (op == SEF_OP_READ && !ok && nreq != 0) chk(st_rd, 32'h0000_0000);
    @(negedge clk);
  endtask
  task automatic guard(input logic [31:0] a, input logic blk);
    soc_v = 1'b1; soc_a = a;
    #2;
    chk({soc_b, soc_g}, {blk, !blk});
    @(negedge clk);
  endtask

  initial begin
    {tmode, win_we, win_idx, win_en, win_wr, part_we, ext_v, ext_w, st_v, soc_v, slow, fail, rd_mode} = '0;
    {wbase, wlim, pbase, plim, ext_a, ext_d, st_a, st_d, soc_a} = '0;
    st_op = SEF_OP_WRITE; nrst = 1'b0; key = 32'hc3a5_9e17; rnd = 16'hb0e2;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    chk({ext_rdy, st_rdy, ext_rv, st_ack, st_err, nv_v, enc_v}, 7'h60);
    guard(32'h0004_0000, 1'b0);
    ext(32'h0000_1000, 1'b0, 1'b0);
    cfg_win(1'b0, 1'b1, 1'b0, 32'h0000_1000, 32'h0000_1fff);
    cfg_win(1'b1, 1'b1, 1'b1, 32'h0000_8000, 32'h0000_80ff);
    foreach (corner[i]) ext(corner[i], 1'b0, 1'b1);
    ext(32'h0000_1000, 1'b1, 1'b1);
    for (int i = 0; i < 60; i++) begin
      rnd = lfsr(rnd);
      slow = rnd[2];
      ext({16'h0000, rnd[15], 2'b00, rnd[12:0]}, rnd[1], 1'b1);
    end
    cfg_win(1'b0, 1'b0, 1'b0, 32'h0000_1000, 32'h0000_1fff);
    ext(32'h0000_1000, 1'b0, 1'b0);
    // Partition and store traffic
    cfg_part(32'h0004_0000, 32'h0004_00ff);
    guard(32'h0003_ffff, 1'b0);
    guard(32'h0004_00ff, 1'b1);
    guard(32'h0004_0100, 1'b0);
    rnd = lfsr(rnd); d1 = {rnd, ~rnd};
    rnd = lfsr(rnd); d2 = {~rnd, rnd};
    st(SEF_OP_WRITE, 32'h0000_0005, d1, 1'b1, 1);
    chk({last_a, 31'h0, last_wd[31:0] === d1}, {32'h0004_0005, 32'h0});
    st(SEF_OP_READ, 32'h0000_0005, d1, 1'b1, 1);
    st(SEF_OP_WRITE, 32'h0000_0005, d2, 1'b1, 1);
    rd_mode = 2'h1;
    st(SEF_OP_READ, 32'h0000_0005, d2, 1'b0, 1);
    rd_mode = 2'h2;
    st(SEF_OP_READ, 32'h0000_0005, d2, 1'b0, 1);
    rd_mode = 2'h0; fail = 1'b1;
    st(SEF_OP_WRITE, 32'h0000_0005, d1, 1'b0, 1);
    fail = 1'b0;
    st(SEF_OP_READ, 32'h0000_0005, d2, 1'b1, 1);
    st(SEF_OP_WRITE, 32'h0000_00ff, d1, 1'b1, 1);
    st(SEF_OP_READ, 32'h0000_00ff, d1, 1'b1, 1);
    st(SEF_OP_WRITE, 32'h0000_0100, d1, 1'b0, 0);
    st(SEF_OP_DELETE, 32'h0000_0005, 32'h0000_0000, 1'b1, 1);
    tmode = 1'b1;
    repeat (4) @(negedge clk);
    st(SEF_OP_READ, 32'h0000_00ff, d1, 1'b0, 0);
    tmode = 1'b0;
    repeat (4) @(negedge clk);
    cfg_part(32'h0004_0000, 32'h0004_000f);
    st(SEF_OP_WRITE, 32'h0000_0010, d1, 1'b0, 0);
    guard(32'h0004_0010, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
